// ==== pkg/sleep_ctrl_params.svh ====
// timing constants and register map for the serial sleep controller
`ifndef SLEEP_CTRL_PARAMS_SVH
`define SLEEP_CTRL_PARAMS_SVH
`define CLK_HZ 40000000
`define FRAME_NS 4616000
`define FRAMES_PER_MULTIFRAME 51
`define FACTOR_MIN 4'h2
`define FACTOR_MAX 4'h9
`define FACTOR_RESET 4'h2
`define CLEAR_LOW_NS 4600000
`define RX_WINDOW_NS 9200000
`define TENTH_NS 100000000
`define FOLLOWUP_MIN_TENTHS 16'h0005
`define FOLLOWUP_MAX_TENTHS 16'h8CA0
`define FOLLOWUP_RESET_TENTHS 16'h0014
`define WAKE_DELAY_MS 60
`define ADDR_LEVEL 12'h000
`define ADDR_FOLLOWUP 12'h004
`define ADDR_FACTOR 12'h008
`define ADDR_CONFIG 12'h00C
`define ADDR_EVENT 12'h010
`define ADDR_STATUS 12'h014
`define LEVEL_RESET 4'h1
`define CFG_HWFLOW_BIT 0
`define CFG_IND_BIT 1
`define CFG_AUTH_BIT 2
`define CFG_ALARM_BIT 3
`define CFG_RESET 4'h0
`endif

// ==== pkg/sleep_ctrl_pkg.sv ====
// types shared by the serial sleep controller
package sleep_ctrl_pkg;
   typedef enum logic [3:0] {
      LVL_NONCYCLIC = 4'h0,
      LVL_FULL = 4'h1,
      LVL_CYCLIC_FIXED = 4'h7,
      LVL_CYCLIC_PROG = 4'h9
   } level_e;
   typedef struct packed {
      logic urc;
      logic call_in;
      logic msg_in;
      logic pkt_xfer;
      logic rtc_alarm;
      logic ignition;
   } wake_events_s;
   typedef struct packed {
      logic rx_start;
      logic tx_pending;
      logic char_done;
   } uart_activity_s;
endpackage

// ==== rtl/serial_sleep_wakeup_control.sv ====
// sleep level control with clear-line scheduling for two serial ports
`timescale 1ns/100ps
`include "sleep_ctrl_params.svh"

// overview of operation
// - one sleep level register selects full operation, non-cyclic sleep or one of two cyclic sleeps
// - full operation (level 1) keeps both clear lines low and never saves power
// - non-cyclic sleep (level 0) blocks the interface and holds both clear lines high
// - in level 0 the paging listen happens internally; the host never sees it
// - any quitting event in level 0 returns the level register to full operation
// - quitting events: result codes, incoming calls, indicated messages, clock alarms
// - a falling request line on either port also quits level 0
// - cyclic sleeps (levels 7 and 9) open the interface in step with the paging cycle
// - each paging wake pulls the clear lines low for a fixed listen time
// - a start bit inside the longer receive window keeps the interface open
// - a pending transmit character also pulls the clear lines low
// - after traffic the follow-up counter holds the interface open
// - level 7 uses a fixed follow-up hold; level 9 uses the programmed one
// - in level 9 a request fall wakes the device temporarily, after a receive delay
// - in level 7 a request fall is flow control only and does not wake
// - ignition and unindicated messages never wake in any level
// - without authentication or in alarm mode the level is kept but not applied
//
// timing notes
// - every count is in system clock cycles, derived from the nanosecond constants and the millisecond wake delay
// - the paging interval is frame time times frames per multiframe times factor
// - the network factor is clamped into its legal range on write
// - the follow-up time is held in tenths of a second and clamped on write
// - follow-up counter width covers the longest hold at the nominal clock
// - the receive delay after a request fall stands in for internal wake latency
//
// register bus notes
// - zero wait state bus: ready is tied high
// - read data is captured in the setup cycle and stands during the access phase
// - unmapped addresses answer with an error and read as zero
// - level writes other than the four defined levels are ignored
// - a level 0 quit takes priority over a level write in the same cycle
// - any register write counts as a serial command for temporary wake
//
// port notes
// - request lines are active low levels, sampled each cycle for falls
// - clear lines are active low, registered, and always identical on both ports
// - uart enable is the inverse of the clear line
// - power saving follows the registered clear line so it never leads it
// - wake events and uart activity are active high and may be single-cycle pulses
//
// hazards and limits
// - request lines are taken as synchronous; an outside synchroniser is expected
// - the clear line reacts one cycle after its cause
// - the paging counter runs free in every level so windows keep their phase
// - changing the factor mid-interval stretches or cuts that one interval only
// - a request fall while already active in level 9 restarts the hold without delay
// - the event counter wraps and never saturates; software clears it by writing
//
// reset notes
// - reset is asynchronous and active low
// - during reset both clear lines are low and power saving is off
// - the request edge detectors reset to the idle high level, so no false fall
// - configuration resets with saving inhibited until authentication is set
//
// test notes
// - all cycle counts are parameters so a bench can shorten them
// - small values keep the paging windows visible within a short run
// - the follow-up load for level 7 uses the reset follow-up value

module serial_sleep_wakeup_control #(
   parameter int CLK_HZ = `CLK_HZ,
   parameter int FRAME_CYCLES = (`FRAME_NS / 1000) * (CLK_HZ / 1000) / 1000,
   parameter int CLEAR_LOW_CYCLES = (`CLEAR_LOW_NS / 1000) * (CLK_HZ / 1000) / 1000,
   parameter int RX_WINDOW_CYCLES = (`RX_WINDOW_NS / 1000) * (CLK_HZ / 1000) / 1000,
   parameter int TENTH_CYCLES = (`TENTH_NS / 1000) * (CLK_HZ / 1000) / 1000,
   parameter int WAKE_DELAY_CYCLES = `WAKE_DELAY_MS * (CLK_HZ / 1000)
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic host_request_line_a,
   input wire logic host_request_line_b,
   output logic device_clear_line_a,
   output logic device_clear_line_b,
   input wire sleep_ctrl_pkg::wake_events_s wake_events,
   input wire sleep_ctrl_pkg::uart_activity_s uart_activity,
   output logic uart_enable,
   output logic power_saving
);
   import sleep_ctrl_pkg::*;

   localparam int PAGE_W = 32;
   // one hour in tenths times the tenth count needs 38 bits
   localparam int FOLLOW_W = 38;

   // register map
   // - level register: low four bits hold the sleep level
   // - follow-up register: low sixteen bits hold tenths of a second
   // - factor register: low four bits hold the network factor
   // - config register: flow control, indication, authentication, alarm mode
   // - event register: count of wake events, cleared by any write
   // - status register: power saving, uart enable, clear line

   level_e level_reg;
   logic [15:0] followup_reg;
   logic [3:0] factor_reg;
   logic [3:0] config_reg;
   logic req_a_reg, req_b_reg;
   logic [PAGE_W-1:0] page_cnt_reg;
   logic [FOLLOW_W-1:0] follow_cnt_reg;
   logic [31:0] wake_delay_reg;
   logic clear_n_reg;
   logic [31:0] event_count_reg;

   logic wr, rd, req_fall, saving_allowed, cyclic, window_low, window_rx, active, page_wrap;
   logic quit_event, temp_event, traffic;
   logic [PAGE_W-1:0] page_period;
   logic [FOLLOW_W-1:0] follow_load;

   // clamp a requested factor into its legal range
   function automatic logic [3:0] clamp_factor(input logic [3:0] f);
      if (f < `FACTOR_MIN) return `FACTOR_MIN;
      else if (f > `FACTOR_MAX) return `FACTOR_MAX;
      else return f;
   endfunction

   // clamp a follow-up time in tenths of a second
   function automatic logic [15:0] clamp_followup(input logic [15:0] t);
      if (t < `FOLLOWUP_MIN_TENTHS) return `FOLLOWUP_MIN_TENTHS;
      else if (t > `FOLLOWUP_MAX_TENTHS) return `FOLLOWUP_MAX_TENTHS;
      else return t;
   endfunction

   // apb strobes, single wait-free access
   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !(paddr == `ADDR_LEVEL || paddr == `ADDR_FOLLOWUP ||
      paddr == `ADDR_FACTOR || paddr == `ADDR_CONFIG || paddr == `ADDR_EVENT || paddr == `ADDR_STATUS);

   // shared request fall detection for both ports
   assign req_fall = (req_a_reg && !host_request_line_a) || (req_b_reg && !host_request_line_b);
   assign cyclic = (level_reg == LVL_CYCLIC_FIXED) || (level_reg == LVL_CYCLIC_PROG);
   assign saving_allowed = config_reg[`CFG_AUTH_BIT] && !config_reg[`CFG_ALARM_BIT];

   // paging interval: frame * 51 * factor
   assign page_period = PAGE_W'(FRAME_CYCLES) * PAGE_W'(`FRAMES_PER_MULTIFRAME) * PAGE_W'(factor_reg);
   assign page_wrap = (page_cnt_reg >= page_period - 1'b1);
   assign window_low = (page_cnt_reg < PAGE_W'(CLEAR_LOW_CYCLES));
   assign window_rx = (page_cnt_reg < PAGE_W'(RX_WINDOW_CYCLES));

   // events that quit level 0, ignition and unindicated messages excluded
   assign quit_event = wake_events.urc || wake_events.call_in || wake_events.rtc_alarm ||
      (wake_events.msg_in && config_reg[`CFG_IND_BIT]);
   // events that wake a cyclic level temporarily
   assign temp_event = quit_event || wake_events.pkt_xfer || wr ||
      (req_fall && level_reg == LVL_CYCLIC_PROG);
   assign traffic = uart_activity.char_done || uart_activity.tx_pending ||
      (uart_activity.rx_start && window_rx);
   assign follow_load = (level_reg == LVL_CYCLIC_PROG) ?
      FOLLOW_W'(followup_reg) * FOLLOW_W'(TENTH_CYCLES) :
      FOLLOW_W'(`FOLLOWUP_RESET_TENTHS) * FOLLOW_W'(TENTH_CYCLES);
   assign active = (follow_cnt_reg != '0) && (wake_delay_reg == '0);

   // sample request lines for edge detection
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         req_a_reg <= 1'b1;
         req_b_reg <= 1'b1;
      end else begin
         req_a_reg <= host_request_line_a;
         req_b_reg <= host_request_line_b;
      end
   end

   // sleep level register, written over apb or quit by wake events
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         level_reg <= LVL_FULL;
      end else if (level_reg == LVL_NONCYCLIC && (quit_event || req_fall)) begin
         level_reg <= LVL_FULL;
      end else if (wr && paddr == `ADDR_LEVEL) begin
         if (pwdata[3:0] == 4'h0) level_reg <= LVL_NONCYCLIC;
         else if (pwdata[3:0] == 4'h7) level_reg <= LVL_CYCLIC_FIXED;
         else if (pwdata[3:0] == 4'h9) level_reg <= LVL_CYCLIC_PROG;
         else if (pwdata[3:0] == 4'h1) level_reg <= LVL_FULL;
      end
   end

   // configuration registers
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         followup_reg <= `FOLLOWUP_RESET_TENTHS;
         factor_reg <= `FACTOR_RESET;
         config_reg <= `CFG_RESET;
      end else if (wr) begin
         if (paddr == `ADDR_FOLLOWUP) followup_reg <= clamp_followup(pwdata[15:0]);
         else if (paddr == `ADDR_FACTOR) factor_reg <= clamp_factor(pwdata[3:0]);
         else if (paddr == `ADDR_CONFIG) config_reg <= pwdata[3:0];
      end
   end

   // paging interval counter
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         page_cnt_reg <= '0;
      end else if (page_wrap) begin
         page_cnt_reg <= '0;
      end else begin
         page_cnt_reg <= page_cnt_reg + 1'b1;
      end
   end

   // follow-up hold after traffic or temporary wake
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         follow_cnt_reg <= '0;
      end else if (!cyclic) begin
         follow_cnt_reg <= '0;
      end else if (traffic || temp_event) begin
         follow_cnt_reg <= follow_load;
      end else if (follow_cnt_reg != '0) begin
         follow_cnt_reg <= follow_cnt_reg - 1'b1;
      end
   end

   // receive-ready delay after a request fall at level 9
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         wake_delay_reg <= '0;
      end else if (req_fall && level_reg == LVL_CYCLIC_PROG && wake_delay_reg == '0 && !active) begin
         wake_delay_reg <= 32'(WAKE_DELAY_CYCLES);
      end else if (wake_delay_reg != '0) begin
         wake_delay_reg <= wake_delay_reg - 1'b1;
      end
   end

   // clear line level, active low, same for both ports
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         clear_n_reg <= 1'b0;
      end else if (!saving_allowed || level_reg == LVL_FULL) begin
         clear_n_reg <= 1'b0;
      end else if (level_reg == LVL_NONCYCLIC) begin
         clear_n_reg <= 1'b1;
      end else begin
         clear_n_reg <= !(window_low || active || traffic);
      end
   end

   // count of wake events seen, for software inspection
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         event_count_reg <= '0;
      end else if (wr && paddr == `ADDR_EVENT) begin
         event_count_reg <= '0;
      end else if (quit_event || temp_event && !wr) begin
         event_count_reg <= event_count_reg + 1'b1;
      end
   end

   // read data
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         prdata <= '0;
      end else if (psel && !penable && !pwrite) begin
         if (paddr == `ADDR_LEVEL) prdata <= {28'h0000000, level_reg};
         else if (paddr == `ADDR_FOLLOWUP) prdata <= {16'h0000, followup_reg};
         else if (paddr == `ADDR_FACTOR) prdata <= {28'h0000000, factor_reg};
         else if (paddr == `ADDR_CONFIG) prdata <= {28'h0000000, config_reg};
         else if (paddr == `ADDR_EVENT) prdata <= event_count_reg;
         else if (paddr == `ADDR_STATUS) prdata <= {29'h00000000, power_saving, uart_enable, clear_n_reg};
         else prdata <= '0;
      end
   end

   // both ports share one clear line state
   assign device_clear_line_a = clear_n_reg;
   assign device_clear_line_b = clear_n_reg;
   assign uart_enable = !clear_n_reg;
   // saving follows the registered clear line so it never leads the blocked interface
   assign power_saving = saving_allowed && clear_n_reg && (level_reg == LVL_NONCYCLIC ||
      cyclic);
endmodule // serial_sleep_wakeup_control

// ==== verification/sleep_ctrl_assertions.sv ====
// port checker for the serial sleep controller
`timescale 1ns/100ps
module sleep_ctrl_assertions (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic host_request_line_a,
   input wire logic host_request_line_b,
   input wire logic device_clear_line_a,
   input wire logic device_clear_line_b,
   input wire sleep_ctrl_pkg::wake_events_s wake_events,
   input wire sleep_ctrl_pkg::uart_activity_s uart_activity,
   input wire logic uart_enable,
   input wire logic power_saving
);
   import sleep_ctrl_pkg::*;
   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   logic [3:0] lvl;
   logic [3:0] cfg;
   wire wr = psel & penable & pwrite;
   // shadow of level and config writes; a level 0 quit returns to 1
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         lvl <= 4'h1;
         cfg <= 4'h0;
      end else begin
         if (wr && paddr == 12'h000 && pwdata[3:0] inside {4'h0, 4'h1, 4'h7, 4'h9}) lvl <= pwdata[3:0];
         if (wr && paddr == 12'h00C) cfg <= pwdata[3:0];
         if (lvl == 4'h0 && ($fell(host_request_line_a) || $fell(host_request_line_b)
            || (wake_events & 6'h32) != 6'h00 || (wake_events.msg_in && cfg[1]))) lvl <= 4'h1;
      end
   end
   chk_ports_alike: assert property (device_clear_line_a == device_clear_line_b)
      else $error("clear lines differ");
   chk_uart_mirror: assert property (uart_enable != device_clear_line_a)
      else $error("uart enable not opposite to clear line");
   chk_reset_full: assert property ($rose(rstn) |-> !device_clear_line_a && !power_saving)
      else $error("not fully active after reset");
   chk_sleep_blocks: assert property (lvl == 4'h0 && $past(lvl) == 4'h0 && power_saving |-> device_clear_line_a)
      else $error("interface open at level 0");
   chk_request_quits: assert property (lvl == 4'h0 && cfg[3:2] == 2'h1
      && ($fell(host_request_line_a) || $fell(host_request_line_b)) |=> !power_saving)
      else $error("request fall did not end saving");
   chk_ignition_idle: assert property (lvl == 4'h0 && power_saving && wake_events == 6'h01
      && host_request_line_a && host_request_line_b |=> device_clear_line_a)
      else $error("ignition woke the device");
   chk_no_auth: assert property (!cfg[2] || cfg[3] |-> !power_saving)
      else $error("saving without authentication");
   chk_full_restore: assert property (wr && paddr == 12'h000 && pwdata == 32'h1
      |-> ##2 !device_clear_line_a && !power_saving)
      else $error("level 1 did not restore full operation");
   cover property (power_saving && device_clear_line_a);
   cover property ($fell(device_clear_line_a));
   cover property (pslverr);
endmodule // sleep_ctrl_assertions
bind serial_sleep_wakeup_control sleep_ctrl_assertions i_sleep_ctrl_assertions (.sys_clk, .rstn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .host_request_line_a, .host_request_line_b,
   .device_clear_line_a, .device_clear_line_b, .wake_events, .uart_activity, .uart_enable, .power_saving);

// ==== verification/host_terminal_model.sv ====
// host terminal model: one request line and start bits
`timescale 1ns/100ps
module host_terminal_model (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic clear_n,
   input wire logic wake_pulse,
   input wire logic send,
   output logic request_n,
   output logic start_bit
);
   // request idles high, pulses low per wake ask, sends only on clear low
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         request_n <= 1'h1;
         start_bit <= 1'h0;
      end else begin
         request_n <= !wake_pulse;
         start_bit <= send && !clear_n;
      end
   end
endmodule // host_terminal_model

// ==== verification/tb_top.sv ====
// self-checking bench for the serial sleep controller
`timescale 1ns/100ps
module tb_top;
   import sleep_ctrl_pkg::*;
   logic sys_clk = 1'h0, rstn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic wk = 1'h0, snd = 1'h0, rqb = 1'h1, txp = 1'h0, cdn = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, e, rqa, clra, clrb, rxs, uen, ps;
   wake_events_s ev = 6'h00;
   wire uart_activity_s ua = {rxs, txp, cdn};
   int bad_count = 0, cmp_count = 0, cyc = 0, seed = 65385, f, t;
   logic [7:0] qe [7] = '{8'h01, 8'h20, 8'h10, 8'h08, 8'h02, 8'h40, 8'h80};
   always #12.5 sys_clk = ~sys_clk;
   serial_sleep_wakeup_control #(.FRAME_CYCLES(20), .CLEAR_LOW_CYCLES(4), .RX_WINDOW_CYCLES(8), .TENTH_CYCLES(10),
      .WAKE_DELAY_CYCLES(5)) i_serial_sleep_wakeup_control (.sys_clk, .rstn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .host_request_line_a(rqa), .host_request_line_b(rqb),
      .device_clear_line_a(clra), .device_clear_line_b(clrb), .wake_events(ev), .uart_activity(ua),
      .uart_enable(uen), .power_saving(ps));
   host_terminal_model i_host_terminal_model (.sys_clk, .rstn, .clear_n(clra), .wake_pulse(wk), .send(snd),
      .request_n(rqa), .start_bit(rxs));
   // cycle count and hang guard
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         bad_count++;
         end_of_test;
      end
   end
   function automatic int clamp(input int v, lo, hi);
      return v < lo ? lo : v > hi ? hi : v;
   endfunction
   task automatic chk(input logic [31:0] g, x);
      cmp_count++;
      if (g !== x) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, g, x);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'h1;
      do @(posedge sys_clk); while (pready !== 1'h1);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      apb(1'h0, a, 32'h0);
      chk(q, x);
   endtask
   task automatic wcl(input logic v);
      while (clra !== v) @(posedge sys_clk);
   endtask
   task automatic end_of_test;
      if (bad_count == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (12) @(posedge sys_clk);
      rstn <= 1'h1;
      rd(12'h000, 32'h1);
      rd(12'h004, 32'h14);
      rd(12'h008, 32'h2);
      rd(12'h014, 32'h2);
      apb(1'h0, 12'h018, 32'h0);
      chk({e, q[30:0]}, 32'h80000000);
      apb(1'h1, 12'h000, 2 + ($random(seed) & 3));
      rd(12'h000, 32'h1);
      apb(1'h1, 12'h000, 32'h0);
      rd(12'h014, 32'h2);
      rd(12'h000, 32'h0);
      apb(1'h1, 12'h00C, 32'h7);
      for (int i = 0; i < 7; i++) begin
         apb(1'h1, 12'h000, 32'h0);
         repeat (3) @(posedge sys_clk);
         chk({ps, clra}, 32'h3);
         ev <= qe[i][5:0];
         wk <= qe[i][6];
         rqb <= ~qe[i][7];
         @(posedge sys_clk);
         ev <= 6'h00;
         wk <= 1'h0;
         rqb <= 1'h1;
         repeat (3) @(posedge sys_clk);
         rd(12'h000, i == 0 ? 32'h0 : 32'h1);
      end
      f = $random(seed) & 15;
      apb(1'h1, 12'h008, f);
      f = clamp(f, 2, 9);
      rd(12'h008, f);
      t = $random(seed) & 32'hFFFF;
      apb(1'h1, 12'h004, t);
      rd(12'h004, clamp(t, 5, 36000));
      apb(1'h1, 12'h004, 32'h3);
      rd(12'h004, 32'h5);
      apb(1'h1, 12'h000, 32'h7);
      wcl(1'h1);
      chk({ps, uen}, 32'h2);
      ev <= 6'h20;
      @(posedge sys_clk);
      ev <= 6'h00;
      rd(12'h000, 32'h7);
      wcl(1'h1);
      wcl(1'h0);
      t = cyc;
      wcl(1'h1);
      chk(cyc - t, 4);
      wcl(1'h0);
      chk(cyc - t, 1020 * f);
      wcl(1'h1);
      txp <= 1'h1;
      repeat (2) @(posedge sys_clk);
      chk(clra, 1'h0);
      txp <= 1'h0;
      cdn <= 1'h1;
      @(posedge sys_clk);
      cdn <= 1'h0;
      repeat (150) @(posedge sys_clk);
      chk(clra, 1'h0);
      apb(1'h1, 12'h000, 32'h9);
      wcl(1'h1);
      wk <= 1'h1;
      @(posedge sys_clk);
      wk <= 1'h0;
      repeat (12) @(posedge sys_clk);
      chk(clra, 1'h0);
      apb(1'h1, 12'h000, 32'h1);
      repeat (2) @(posedge sys_clk);
      rd(12'h014, 32'h2);
      end_of_test;
   end
endmodule // tb_top
